// [shared/tlc_pkg.sv]
// Constants, types and register layout shared by both link ends.
// Assumes nothing; both ends and the interface use it by scoped name.
package tlc_pkg;

    // ----------------------------------------------------------------
    // Channel configuration and loopback modes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        TLC_CFG_CUSTOM,
        TLC_CFG_PCIE,
        TLC_CFG_CUSTOM_REV,
        TLC_CFG_CUSTOM_PRECDR
    } tlc_cfg_t;

    typedef enum logic [2:0] {
        TLC_LB_NONE,
        TLC_LB_SERIAL,
        TLC_LB_PCIE_REV,
        TLC_LB_REV_SERIAL,
        TLC_LB_PRE_CDR
    } tlc_mode_t;

    // Analog control selectors
    localparam logic [1:0] SEL_SWING    = 2'h0;
    localparam logic [1:0] SEL_POST_TAP = 2'h1;
    localparam logic [1:0] SEL_EQ_CTRL  = 2'h2;
    localparam logic [1:0] SEL_EQ_DC    = 2'h3;

    // ----------------------------------------------------------------
    // Defaults and timing counts (parallel clock cycles)
    // ----------------------------------------------------------------
    localparam int         NCH_DEF            = 4;
    localparam int         WORD_DEF           = 20;
    localparam int         PCIE_GEN_MAX_LB    = 2;
    localparam logic [3:0] RX_RST_MIN_CYCLES  = 4'h2;
    localparam logic [7:0] LOCK_CYCLES        = 8'h10;
    localparam logic [7:0] OFFSET_CAL_CYCLES  = 8'h40;
    localparam logic [7:0] RECFG_CYCLES       = 8'h08;
    localparam logic [7:0] ALIGN_CYCLES       = 8'h08;
    localparam logic [7:0] SETTING_RST        = 8'h00;

    // ----------------------------------------------------------------
    // Controller register map (byte offsets) and fields
    // ----------------------------------------------------------------
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_STATUS   = 8'h04;
    localparam logic [7:0]  OFS_RECFG    = 8'h08;
    localparam logic [7:0]  OFS_ALIGN    = 8'h0C;
    localparam int          CTRL_PCIE_POS = 8;
    localparam int          ST_LOCK_POS   = 8;
    localparam int          ST_BUSY_BIT   = 16;
    localparam int          ST_PEND_BIT   = 17;
    localparam int          RCF_SEL_POS   = 0;
    localparam int          RCF_CH_POS    = 4;
    localparam int          RCF_VAL_POS   = 8;
    localparam logic [31:0] ALIGN_RST     = 32'h0000_0283;

endpackage : tlc_pkg

// [shared/tlc_link_if.sv]
// Interface joining the transceiver end and the fabric controller end.
// Assumes both ends run on the same parallel clock.
`timescale 1ns/1ps
interface tlc_link_if #(
    parameter int NCH = tlc_pkg::NCH_DEF,
    parameter int W   = tlc_pkg::WORD_DEF
);
    // ----------------------------------------------------------------
    // Per-channel data and control
    // ----------------------------------------------------------------
    logic [NCH-1:0][W-1:0] tx_word;
    logic [NCH-1:0]        serial_lb_req;
    logic [NCH-1:0]        pcie_lb_req;
    logic [NCH-1:0]        rx_digital_reset;
    logic [NCH-1:0][W-1:0] rx_word;
    logic [NCH-1:0]        rx_valid;
    logic [NCH-1:0]        cdr_locked;
    // Analog control reconfiguration
    logic                  reconfig_busy;
    logic                  reconfig_wr;
    logic [1:0]            reconfig_sel;
    logic [7:0]            reconfig_ch;
    logic [7:0]            reconfig_val;

    modport dev (
        input  tx_word, serial_lb_req, pcie_lb_req, rx_digital_reset,
        input  reconfig_wr, reconfig_sel, reconfig_ch, reconfig_val,
        output rx_word, rx_valid, cdr_locked, reconfig_busy
    );
    modport host (
        output tx_word, serial_lb_req, pcie_lb_req, rx_digital_reset,
        output reconfig_wr, reconfig_sel, reconfig_ch, reconfig_val,
        input  rx_word, rx_valid, cdr_locked, reconfig_busy
    );
endinterface : tlc_link_if

// [src/tlc_xcvr.sv]
// Transceiver end: loopback selection, receive path and analog settings.
// Assumes the fabric end drives the link and line words arrive per clock.
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
// What this block does
// - Serial loopback allowed only in the custom configuration
// - Serial loopback drives line and local receiver
// - Looped data skips input buffer, reaches fabric
// - Serial loopback switchable per channel at run time
// - Receive reset held two cycles on loopback change
// - Receive reset held while recovery retracks source
// - Alignment pattern sent for eight cycles after receive reset in serial loopback
// - PCIe reverse loopback only PCIe, first two generations
// - PCIe reverse path: recovery, deserialize, align, rate-match
// - PCIe reverse loopback also delivers words to fabric
// - PCIe loopback request input selects reverse loopback
// - PCIe configuration allows only reverse parallel loopback
// - Far-end reverse loopback retimes line, also to fabric
// - Far-end reverse loopback fixed, no run-time control
// - Far-end reverse: swing, tap, equalization and DC gain all adjustable
// - Pre-recovery loopback routes line before recovery, fabric too
// - Pre-recovery loopback: tap fixed, swing configurable
// - No reconfiguration before offset cancellation completes
// - Each reconfiguration only while busy flag low
// - Reconfigure swing, taps, equalization and DC gain
module tlc_xcvr #(
    parameter tlc_pkg::tlc_cfg_t CFG_TYPE = tlc_pkg::TLC_CFG_CUSTOM,
    parameter int                PCIE_GEN = 1,
    parameter int                NCH      = tlc_pkg::NCH_DEF,
    parameter int                W        = tlc_pkg::WORD_DEF
) (
    input  wire logic                  core_clk_in,
    input  wire logic                  rst_n_in,
    tlc_link_if.dev                    lnk,
    input  wire logic [NCH-1:0][W-1:0] line_rx_in,
    output logic      [NCH-1:0][W-1:0] line_tx_out,
    output logic      [NCH-1:0][2:0]   mode_out,
    output logic      [NCH-1:0][7:0]   swing_out,
    output logic      [NCH-1:0][7:0]   post_tap_out,
    output logic      [NCH-1:0][7:0]   eq_ctrl_out,
    output logic      [NCH-1:0][7:0]   eq_dc_out
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        tlc_pkg::tlc_mode_t [NCH-1:0] mode;
        logic [NCH-1:0]               src_local;
        logic [NCH-1:0][7:0]          lock_cnt;
        logic [NCH-1:0][W-1:0]        des;
        logic [NCH-1:0][W-1:0]        aln;
        logic [NCH-1:0][W-1:0]        rmf;
        logic [NCH-1:0][W-1:0]        rx_word;
        logic [NCH-1:0]               rx_valid;
        logic [NCH-1:0][W-1:0]        line_tx;
        logic [NCH-1:0][7:0]          swing;
        logic [NCH-1:0][7:0]          post_tap;
        logic [NCH-1:0][7:0]          eq_ctrl;
        logic [NCH-1:0][7:0]          eq_dc;
        logic [7:0]                   busy_cnt;
    } tlc_xcvr_st_t;

    tlc_xcvr_st_t st_ff;
    tlc_xcvr_st_t nxt_st;

    // Capability of this configuration
    localparam bit PCIE_LB_OK = (CFG_TYPE == tlc_pkg::TLC_CFG_PCIE)
                              && (PCIE_GEN <= tlc_pkg::PCIE_GEN_MAX_LB);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    // Mode resolution, receive path, line drive and reconfiguration
    always_comb begin
        tlc_pkg::tlc_mode_t m;
        logic [W-1:0]       src;
        logic               busy;
        m      = tlc_pkg::TLC_LB_NONE;
        src    = '0;
        busy   = (st_ff.busy_cnt != 8'h00);
        nxt_st = st_ff;
        for (int c = 0; c < NCH; c++) begin
            // One mode per channel, unsupported requests dropped
            unique case (CFG_TYPE)
                tlc_pkg::TLC_CFG_CUSTOM: begin
                    m = lnk.serial_lb_req[c] ? tlc_pkg::TLC_LB_SERIAL
                                             : tlc_pkg::TLC_LB_NONE;
                end
                tlc_pkg::TLC_CFG_PCIE: begin
                    m = (PCIE_LB_OK && lnk.pcie_lb_req[c])
                      ? tlc_pkg::TLC_LB_PCIE_REV
                      : tlc_pkg::TLC_LB_NONE;
                end
                tlc_pkg::TLC_CFG_CUSTOM_REV: begin
                    m = tlc_pkg::TLC_LB_REV_SERIAL;
                end
                tlc_pkg::TLC_CFG_CUSTOM_PRECDR: begin
                    m = tlc_pkg::TLC_LB_PRE_CDR;
                end
            endcase
            nxt_st.mode[c] = m;

            // Recovery relocks whenever the receive source changes
            nxt_st.src_local[c] = (m == tlc_pkg::TLC_LB_SERIAL);
            if (nxt_st.src_local[c] != st_ff.src_local[c]) begin
                nxt_st.lock_cnt[c] = tlc_pkg::LOCK_CYCLES;
            end else if (st_ff.lock_cnt[c] != 8'h00) begin
                nxt_st.lock_cnt[c] = st_ff.lock_cnt[c] - 8'h01;
            end

            // Receive source: local transmitter bypasses input buffer
            src = st_ff.src_local[c] ? lnk.tx_word[c] : line_rx_in[c];
            nxt_st.des[c] = src;
            nxt_st.aln[c] = st_ff.des[c];
            nxt_st.rmf[c] = st_ff.aln[c];

            // Words to fabric, blanked while receive logic is in reset
            if (lnk.rx_digital_reset[c] || (st_ff.lock_cnt[c] != 8'h00)) begin
                nxt_st.rx_word[c]  = '0;
                nxt_st.rx_valid[c] = 1'b0;
            end else begin
                nxt_st.rx_word[c]  = st_ff.rmf[c];
                nxt_st.rx_valid[c] = 1'b1;
            end

            // Line output source per mode
            unique case (st_ff.mode[c])
                tlc_pkg::TLC_LB_PCIE_REV: begin
                    nxt_st.line_tx[c] = st_ff.rmf[c];
                end
                tlc_pkg::TLC_LB_REV_SERIAL: begin
                    nxt_st.line_tx[c] = st_ff.des[c];
                end
                tlc_pkg::TLC_LB_PRE_CDR: begin
                    nxt_st.line_tx[c] = line_rx_in[c];
                end
                default: begin
                    nxt_st.line_tx[c] = lnk.tx_word[c];
                end
            endcase
        end

        // Busy flag counts down offset cancellation or a change
        if (busy) begin
            nxt_st.busy_cnt = st_ff.busy_cnt - 8'h01;
        end else if (lnk.reconfig_wr) begin
            nxt_st.busy_cnt = tlc_pkg::RECFG_CYCLES;
            for (int c = 0; c < NCH; c++) begin
                if (lnk.reconfig_ch == 8'(c)) begin
                    unique case (lnk.reconfig_sel)
                        tlc_pkg::SEL_SWING: begin
                            nxt_st.swing[c] = lnk.reconfig_val;
                        end
                        tlc_pkg::SEL_POST_TAP: begin
                            // Tap stays fixed ahead of recovery
                            if (st_ff.mode[c] != tlc_pkg::TLC_LB_PRE_CDR) begin
                                nxt_st.post_tap[c] = lnk.reconfig_val;
                            end
                        end
                        tlc_pkg::SEL_EQ_CTRL: begin
                            nxt_st.eq_ctrl[c] = lnk.reconfig_val;
                        end
                        tlc_pkg::SEL_EQ_DC: begin
                            nxt_st.eq_dc[c] = lnk.reconfig_val;
                        end
                    endcase
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // State register, offset cancellation starts at reset
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_ff          <= '0;
            st_ff.mode     <= '{default: tlc_pkg::TLC_LB_NONE};
            st_ff.swing    <= {NCH{tlc_pkg::SETTING_RST}};
            st_ff.post_tap <= {NCH{tlc_pkg::SETTING_RST}};
            st_ff.eq_ctrl  <= {NCH{tlc_pkg::SETTING_RST}};
            st_ff.eq_dc    <= {NCH{tlc_pkg::SETTING_RST}};
            st_ff.busy_cnt <= tlc_pkg::OFFSET_CAL_CYCLES;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Link side
    assign lnk.rx_word       = st_ff.rx_word;
    assign lnk.rx_valid      = st_ff.rx_valid;
    assign lnk.reconfig_busy = (st_ff.busy_cnt != 8'h00);

    // Per-channel lock and user outputs
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        assign lnk.cdr_locked[c] = (st_ff.lock_cnt[c] == 8'h00);
        assign mode_out[c]       = st_ff.mode[c];
    end

    // Output buffer only, settings always applied
    assign line_tx_out  = st_ff.line_tx;
    assign swing_out    = st_ff.swing;
    assign post_tap_out = st_ff.post_tap;
    assign eq_ctrl_out  = st_ff.eq_ctrl;
    assign eq_dc_out    = st_ff.eq_dc;

endmodule : tlc_xcvr

// [src/tlc_ctrl.sv]
// Fabric end: APB registers, receive reset sequencing, alignment and
// reconfiguration issue. Assumes an APB master on the same clock.
`timescale 1ns/1ps
module tlc_ctrl #(
    parameter int NCH = tlc_pkg::NCH_DEF,
    parameter int W   = tlc_pkg::WORD_DEF
) (
    input  wire logic                  core_clk_in,
    input  wire logic                  rst_n_in,
    tlc_link_if.host                   lnk,
    input  wire logic                  psel_in,
    input  wire logic                  penable_in,
    input  wire logic                  pwrite_in,
    input  wire logic [7:0]            paddr_in,
    input  wire logic [31:0]           pwdata_in,
    output logic      [31:0]           prdata_out,
    output logic                       pready_out,
    output logic                       pslverr_out,
    input  wire logic [NCH-1:0][W-1:0] tx_data_in,
    output logic      [NCH-1:0][W-1:0] rx_data_out,
    output logic      [NCH-1:0]        rx_valid_out
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [NCH-1:0]        serial_en;
        logic [NCH-1:0]        pcie_en;
        logic [W-1:0]          align_pat;
        logic [NCH-1:0][3:0]   rst_cnt;
        logic [NCH-1:0]        rx_rst;
        logic [NCH-1:0][7:0]   align_cnt;
        logic [NCH-1:0][W-1:0] tx_word;
        logic [NCH-1:0][W-1:0] rx_data;
        logic [NCH-1:0]        rx_valid;
        logic                  pend;
        logic [1:0]            rcf_sel;
        logic [7:0]            rcf_ch;
        logic [7:0]            rcf_val;
        logic                  rcf_wr;
        logic [31:0]           prdata;
    } tlc_ctrl_st_t;

    tlc_ctrl_st_t st_ff;
    tlc_ctrl_st_t nxt_st;
    logic         mapped;
    logic         wr_acc;

    // Address decode and write strobe
    assign mapped = (paddr_in == tlc_pkg::OFS_CTRL) || (paddr_in == tlc_pkg::OFS_STATUS)
                 || (paddr_in == tlc_pkg::OFS_RECFG) || (paddr_in == tlc_pkg::OFS_ALIGN);
    assign wr_acc = psel_in && penable_in && pwrite_in;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st        = st_ff;
        nxt_st.rcf_wr = 1'b0;
        // Register writes
        if (wr_acc && (paddr_in == tlc_pkg::OFS_CTRL)) begin
            nxt_st.serial_en = pwdata_in[NCH-1:0];
            nxt_st.pcie_en   = pwdata_in[tlc_pkg::CTRL_PCIE_POS +: NCH];
        end
        if (wr_acc && (paddr_in == tlc_pkg::OFS_ALIGN)) begin
            nxt_st.align_pat = pwdata_in[W-1:0];
        end
        if (wr_acc && (paddr_in == tlc_pkg::OFS_RECFG) && !st_ff.pend) begin
            nxt_st.pend    = 1'b1;
            nxt_st.rcf_sel = pwdata_in[tlc_pkg::RCF_SEL_POS +: 2];
            nxt_st.rcf_ch  = {4'h0, pwdata_in[tlc_pkg::RCF_CH_POS +: 4]};
            nxt_st.rcf_val = pwdata_in[tlc_pkg::RCF_VAL_POS +: 8];
        end
        // Issue one pending change once the busy flag is low
        if (st_ff.pend && !lnk.reconfig_busy && !st_ff.rcf_wr) begin
            nxt_st.rcf_wr = 1'b1;
            nxt_st.pend   = 1'b0;
        end

        // Per-channel reset sequencing and alignment
        for (int c = 0; c < NCH; c++) begin
            if (nxt_st.serial_en[c] != st_ff.serial_en[c]) begin
                nxt_st.rst_cnt[c] = tlc_pkg::RX_RST_MIN_CYCLES;
            end else if (st_ff.rst_cnt[c] != 4'h0) begin
                nxt_st.rst_cnt[c] = st_ff.rst_cnt[c] - 4'h1;
            end
            nxt_st.rx_rst[c] = (nxt_st.rst_cnt[c] != 4'h0)
                            || !lnk.cdr_locked[c];
            if (st_ff.rx_rst[c]) begin
                nxt_st.align_cnt[c] = tlc_pkg::ALIGN_CYCLES;
            end else if (st_ff.align_cnt[c] != 8'h00) begin
                nxt_st.align_cnt[c] = st_ff.align_cnt[c] - 8'h01;
            end
            if (st_ff.serial_en[c] && (st_ff.align_cnt[c] != 8'h00)) begin
                nxt_st.tx_word[c] = st_ff.align_pat;
            end else begin
                nxt_st.tx_word[c] = tx_data_in[c];
            end
        end
        nxt_st.rx_data  = lnk.rx_word;
        nxt_st.rx_valid = lnk.rx_valid;

        // Read data captured in the setup cycle
        if (psel_in && !penable_in) begin
            nxt_st.prdata = 32'h0000_0000;
            if (paddr_in == tlc_pkg::OFS_CTRL) begin
                nxt_st.prdata[NCH-1:0]                  = st_ff.serial_en;
                nxt_st.prdata[tlc_pkg::CTRL_PCIE_POS +: NCH] = st_ff.pcie_en;
            end else if (paddr_in == tlc_pkg::OFS_STATUS) begin
                nxt_st.prdata[NCH-1:0]                  = st_ff.rx_rst;
                nxt_st.prdata[tlc_pkg::ST_LOCK_POS +: NCH] = lnk.cdr_locked;
                nxt_st.prdata[tlc_pkg::ST_BUSY_BIT]     = lnk.reconfig_busy;
                nxt_st.prdata[tlc_pkg::ST_PEND_BIT]     = st_ff.pend;
            end else if (paddr_in == tlc_pkg::OFS_RECFG) begin
                nxt_st.prdata[tlc_pkg::RCF_SEL_POS +: 2] = st_ff.rcf_sel;
                nxt_st.prdata[tlc_pkg::RCF_CH_POS +: 4]  = st_ff.rcf_ch[3:0];
                nxt_st.prdata[tlc_pkg::RCF_VAL_POS +: 8] = st_ff.rcf_val;
            end else if (paddr_in == tlc_pkg::OFS_ALIGN) begin
                nxt_st.prdata[W-1:0] = st_ff.align_pat;
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_ff           <= '0;
            st_ff.rx_rst    <= {NCH{1'b1}};
            st_ff.align_pat <= tlc_pkg::ALIGN_RST[W-1:0];
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign lnk.tx_word          = st_ff.tx_word;
    assign lnk.serial_lb_req    = st_ff.serial_en;
    assign lnk.pcie_lb_req      = st_ff.pcie_en;
    assign lnk.rx_digital_reset = st_ff.rx_rst;
    assign lnk.reconfig_wr      = st_ff.rcf_wr;
    assign lnk.reconfig_sel     = st_ff.rcf_sel;
    assign lnk.reconfig_ch      = st_ff.rcf_ch;
    assign lnk.reconfig_val     = st_ff.rcf_val;
    assign rx_data_out          = st_ff.rx_data;
    assign rx_valid_out         = st_ff.rx_valid;
    assign prdata_out           = st_ff.prdata;
    assign pready_out           = 1'b1;            // Zero wait states
    assign pslverr_out          = psel_in && penable_in && !mapped;

endmodule : tlc_ctrl

// [verification/tlc_link_asserts.sv]
// Checker watching the link between the transceiver end and the controller end.
// Assumes one clock domain; the bench hands in the link signals by name.
`timescale 1ns/1ps
module tlc_link_asserts #(
    parameter int NCH = tlc_pkg::NCH_DEF
) (
    input  wire logic           core_clk_in,
    input  wire logic           rst_n_in,
    input  wire logic [NCH-1:0] serial_lb_req,
    input  wire logic [NCH-1:0] rx_digital_reset,
    input  wire logic [NCH-1:0] cdr_locked,
    input  wire logic           reconfig_busy,
    input  wire logic           reconfig_wr
);
    // ------------------------------------------------------------
    // Cycles since reset release, saturating
    // ------------------------------------------------------------
    logic [7:0] cal_cnt_ff;
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cal_cnt_ff <= 8'h00;
        end else if (cal_cnt_ff != 8'hFF) begin
            cal_cnt_ff <= cal_cnt_ff + 8'h01;
        end
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    // ------------------------------------------------------------
    // Receive reset, relock and reconfiguration handshake
    // ------------------------------------------------------------
    property p_rst_two; $changed(serial_lb_req[0]) |-> rx_digital_reset[0] [*2]; endproperty
    a_rst_two: assert property (p_rst_two) else $error("short rx reset");
    property p_rst_rose; $rose(rx_digital_reset[0]) |=> rx_digital_reset[0]; endproperty
    a_rst_rose: assert property (p_rst_rose) else $error("one cycle rx reset");
    property p_relock; $changed(serial_lb_req[0]) |-> ##[1:4] !cdr_locked[0]; endproperty
    a_relock: assert property (p_relock) else $error("no relock");
    property p_lock_hold; $fell(cdr_locked[0]) |-> !cdr_locked[0] [*8]; endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("lock too soon");
    property p_rst_unlock; !cdr_locked[0] && !$past(cdr_locked[0]) |-> rx_digital_reset[0];
    endproperty
    a_rst_unlock: assert property (p_rst_unlock) else $error("rx out of reset unlocked");
    property p_cal; cal_cnt_ff < tlc_pkg::OFFSET_CAL_CYCLES |-> reconfig_busy; endproperty
    a_cal: assert property (p_cal) else $error("busy low during cal");
    property p_wr_idle; reconfig_wr |-> !reconfig_busy; endproperty
    a_wr_idle: assert property (p_wr_idle) else $error("write while busy");
    property p_wr_busy; reconfig_wr |=> !reconfig_wr ##0 reconfig_busy [*8]; endproperty
    a_wr_busy: assert property (p_wr_busy) else $error("busy not held");
endmodule : tlc_link_asserts

// [verification/tb_top.sv]
// Bench joining both ends over the link; drives APB and line words.
// Assumes the custom configuration with four channels of 20 bits.
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("unexpected at %0t: value mismatch", $time); end end
module tb_top;
    logic             core_clk_in = 1'b0;
    logic             rst_n_in    = 1'b0;
    logic             psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0]       paddr = 8'h00;
    logic [31:0]      pwdata = 32'h0, prdata, r;
    logic             pready, pslverr, e;
    logic [3:0][19:0] tx_data = {4{20'hABCDE}}, line_rx = {4{20'h12345}}, rx_data, line_tx;
    logic [3:0]       rx_valid;
    logic [3:0][2:0]  mode;
    logic [3:0][7:0]  swing, tap, eq, dc;
    int               mismatches = 0, num_checks = 0;
    always #12.5 core_clk_in = ~core_clk_in;
    tlc_link_if #(.NCH(4), .W(20)) lnk ();
    tlc_xcvr u_tlc_xcvr (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .lnk(lnk),
        .line_rx_in(line_rx), .line_tx_out(line_tx), .mode_out(mode), .swing_out(swing),
        .post_tap_out(tap), .eq_ctrl_out(eq), .eq_dc_out(dc));
    tlc_ctrl u_tlc_ctrl (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .lnk(lnk),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .tx_data_in(tx_data), .rx_data_out(rx_data), .rx_valid_out(rx_valid));
    tlc_link_asserts #(.NCH(4)) u_tlc_link_asserts (.core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in), .serial_lb_req(lnk.serial_lb_req),
        .rx_digital_reset(lnk.rx_digital_reset), .cdr_locked(lnk.cdr_locked),
        .reconfig_busy(lnk.reconfig_busy), .reconfig_wr(lnk.reconfig_wr));
    // ------------------------------------------------------------
    // APB transfer, verdict and settle helpers
    // ------------------------------------------------------------
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk_in);
        pen <= 1'b1;
        do @(posedge core_clk_in); while (pready !== 1'b1);
        r = prdata; e = pslverr;
        psel <= 1'b0; pen <= 1'b0;
    endtask : apb
    task settle(input int n);
        repeat (n) @(posedge core_clk_in);
        @(negedge core_clk_in);
    endtask : settle
    task wrap_up;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : wrap_up
    // Watchdog against a hang
    initial begin
        repeat (3000) @(posedge core_clk_in);
        mismatches++;
        wrap_up();
    end
    // Main sequence
    initial begin
        repeat (4) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        apb(1'b0, tlc_pkg::OFS_STATUS, 32'h0); `CHK(r[16], 1'b1)
        apb(1'b0, 8'h10, 32'h0); `CHK(e, 1'b1)
        `CHK(r, 32'h0)
        settle(70);
        apb(1'b0, tlc_pkg::OFS_STATUS, 32'h0); `CHK(r[16], 1'b0)
        `CHK(r[11:0], 12'hF00)
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, tlc_pkg::OFS_RECFG, {16'h0, 8'h30 + 8'(s), 8'h10 | 8'(s)});
            settle(20);
        end
        `CHK({swing[1], tap[1], eq[1], dc[1]}, 32'h30313233)
        // Second change queues behind the first until busy drops
        apb(1'b1, tlc_pkg::OFS_RECFG, 32'h1120);
        apb(1'b1, tlc_pkg::OFS_RECFG, 32'h2220);
        settle(0); `CHK(swing[2], 8'h11)
        settle(20); `CHK(swing[2], 8'h22)
        apb(1'b1, tlc_pkg::OFS_CTRL, 32'h1);
        settle(2); `CHK(mode[0], tlc_pkg::TLC_LB_SERIAL)
        `CHK(mode[1], tlc_pkg::TLC_LB_NONE)
        while (lnk.rx_digital_reset[0] !== 1'b0) @(negedge core_clk_in);
        settle(2); `CHK(lnk.tx_word[0], tlc_pkg::ALIGN_RST[19:0])
        @(posedge core_clk_in);
        tx_data[0] <= 20'h5A5A5;
        settle(30);
        `CHK(rx_data[0], 20'h5A5A5)
        `CHK(line_tx[0], 20'h5A5A5)
        `CHK({rx_valid[0], rx_data[1]}, {1'b1, 20'h12345})
        apb(1'b1, tlc_pkg::OFS_CTRL, 32'h101);
        settle(4); `CHK(mode[0], tlc_pkg::TLC_LB_SERIAL)
        apb(1'b1, tlc_pkg::OFS_CTRL, 32'h0);
        settle(4); `CHK(mode[0], tlc_pkg::TLC_LB_NONE)
        wrap_up();
    end
endmodule : tb_top
